// ==== bench/uart_flag_status_logic_test.sv ====
// Purpose: directed register-level test of the serial flag status block
// Assumes: classic Wishbone single cycles, flag word in bits 7:3
// Notes: busy only drops after a shift-done pulse, so each mode ends with one
`timescale 1ns/1ps
`default_nettype none
module uart_flag_status_logic_test;
  logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, fifo_mode_enable = 1'h0, shd = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dati = 32'h0, dato, rdv;
  logic ack, irq;
  ufs_pkg::ufs_occ_t occ = 6'h24;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  uart_flag_status_logic DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dati), .wb_dat_o(dato),
    .wb_ack_o(ack), .occ(occ), .fifoModeEnable(fifo_mode_enable), .shiftDone(shd), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dati} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (ack !== 1'h1) bad_count++;
    rdv = dato;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk("read", e, rdv);
  endtask
  task automatic put(input logic f, input logic [5:0] o);
    @(posedge clk);
    fifo_mode_enable <= f;
    occ <= o;
  endtask
  task automatic done;
    @(posedge clk);
    shd <= 1'h1;
    @(posedge clk);
    shd <= 1'h0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h18, 32'h90);
    rd(8'h44, 32'h0);
    rd(8'h00, 32'h0);
    bus(1'h1, 8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h90);
    put(1'h0, 6'h2D);
    rd(8'h18, 32'h68);
    put(1'h0, 6'h25);
    rd(8'h18, 32'hC8);
    done;
    rd(8'h18, 32'hC0);
    put(1'h1, 6'h12);
    rd(8'h18, 32'h68);
    put(1'h1, 6'h2D);
    rd(8'h18, 32'h98);
    done;
    rd(8'h18, 32'h90);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'h1, 8'h44, 32'hF8);
    rd(8'h44, 32'hF8);
    bus(1'h1, 8'h40, 32'hF8);
    rd(8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    put(1'h1, 6'h22);
    rd(8'h40, 32'h40);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'h1, 8'h44, 32'hB8);
    chk("irq", 32'h0, {31'h0, irq});
    give_verdict;
  end
  // far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule // uart_flag_status_logic_test
`default_nettype wire

// ==== bench/ufs_checker_asserts.sv ====
// Purpose: bus and flag checks for the serial flag status block
// Assumes: read data is captured at the edge that takes the request
// Notes: flags are judged from read data against occupancy
`timescale 1ns/1ps
`default_nettype none
module ufs_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ufs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [ufs_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ufs_pkg::ufs_occ_t occ,
  input wire logic fifoModeEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd; s_take ##0 !wb_we_i && wb_adr_i == ufs_pkg::FLAG_OFS; endsequence
  property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_resv; wb_ack_o |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[2:0] == 3'h0; endproperty
  property p_txeh; s_rd ##0 !fifoModeEnable |=> wb_dat_o[7] == !$past(occ.txHoldFull); endproperty
  property p_txef; s_rd ##0 fifoModeEnable |=> wb_dat_o[7] == $past(occ.txFifoEmpty); endproperty
  property p_rxf; s_rd |=> wb_dat_o[6] == $past(fifoModeEnable ? occ.rxFifoFull : occ.rxHoldFull);
  endproperty
  property p_txf; s_rd |=> wb_dat_o[5] == $past(fifoModeEnable ? occ.txFifoFull : occ.txHoldFull);
  endproperty
  property p_rxe; s_rd |=> wb_dat_o[4] == $past(fifoModeEnable ? occ.rxFifoEmpty : !occ.rxHoldFull);
  endproperty
  property p_busy; s_rd ##0 (fifoModeEnable ? !occ.txFifoEmpty : occ.txHoldFull) |=> wb_dat_o[3];
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_resv: assert property (p_resv) else $error("reserved read bits not zero");
  a_txeh: assert property (p_txeh) else $error("tx empty wrong in holding mode");
  a_txef: assert property (p_txef) else $error("tx empty wrong in fifo mode");
  a_rxf: assert property (p_rxf) else $error("rx full flag wrong");
  a_txf: assert property (p_txf) else $error("tx full flag wrong");
  a_rxe: assert property (p_rxe) else $error("rx empty flag wrong");
  a_busy: assert property (p_busy) else $error("busy low with tx data queued");
endmodule // ufs_checker
bind uart_flag_status_logic ufs_checker u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .occ(occ), .fifoModeEnable(fifoModeEnable));
`default_nettype wire

// ==== include/ufs_pkg.sv ====
// Purpose: shared constants and types for the serial flag status block
// Assumes: 32-bit classic Wishbone register access, byte addressing
// Notes: flag, interrupt status and mask registers share the bit 7:3 layout
`default_nettype none

package ufs_pkg;

  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;

  // register byte offsets
  localparam logic [ADR_W-1:0] FLAG_OFS = 8'h18;
  localparam logic [ADR_W-1:0] INT_STATUS_OFS = 8'h40;
  localparam logic [ADR_W-1:0] INT_MASK_OFS = 8'h44;

  // field positions inside the flag word
  localparam int unsigned TX_EMPTY_BIT = 7;
  localparam int unsigned RX_FULL_BIT = 6;
  localparam int unsigned TX_FULL_BIT = 5;
  localparam int unsigned RX_EMPTY_BIT = 4;
  localparam int unsigned BUSY_BIT = 3;
  localparam int unsigned FLAG_LSB = 3;
  localparam int unsigned FLAG_W = 5;

  // reset values
  localparam logic [DAT_W-1:0] FLAG_RESET = 32'h0000_0090;
  localparam logic [FLAG_W-1:0] FLAG_FIELD_RESET = 5'h12;
  localparam logic [FLAG_W-1:0] INT_STATUS_RESET = 5'h00;
  localparam logic [FLAG_W-1:0] INT_MASK_RESET = 5'h00;

  // order matches bits 7:3 of the flag word
  typedef struct packed {
    logic txEmpty;
    logic rxFull;
    logic txFull;
    logic rxEmpty;
    logic busy;
  } ufs_flags_t;

  // occupancy reported by the fifos and holding registers
  typedef struct packed {
    logic txFifoEmpty;
    logic txFifoFull;
    logic txHoldFull;
    logic rxFifoEmpty;
    logic rxFifoFull;
    logic rxHoldFull;
  } ufs_occ_t;

  function automatic logic [DAT_W-1:0] ufs_place_field(input logic [FLAG_W-1:0] field);
    ufs_place_field = {{(DAT_W-FLAG_W-FLAG_LSB){1'b0}}, field, {FLAG_LSB{1'b0}}};
  endfunction

endpackage

`default_nettype wire

// ==== logic/uart_flag_status_logic.sv ====
// Purpose: serial transceiver flag register with sticky flag-change interrupts
// Assumes: classic Wishbone slave; occupancy and shiftDone on the same clock
// Notes:
// Notes on behaviour
// - holding-register mode: transmit-empty set while transmit holding register is vacant.
// - fifo mode: transmit-empty set while the transmit fifo has no entries.
// - receive-full follows holding register occupied, or receive fifo full.
// - transmit-full follows holding register occupied, or transmit fifo full.
// - receive-empty follows holding register vacant, or receive fifo empty.
// - busy stays set until the shift engine finishes the character and stop bits.
// - busy sets as soon as transmit data is queued, even with port disabled.
// - after reset both empty flags read 1, other flags and reserved bits 0.
// - flag register is read-only; bits 2:0 and 31:8 read as zero.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uart_flag_status_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ufs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ufs_pkg::DAT_W-1:0] wb_dat_i,
  output logic [ufs_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ufs_pkg::ufs_occ_t occ,
  input wire logic fifoModeEnable,
  input wire logic shiftDone,
  output logic irq
);

  ufs_pkg::ufs_flags_t flags;
  ufs_pkg::ufs_flags_t prevFlags;
  ufs_pkg::ufs_flags_t next_prevFlags;
  logic busyHold;
  logic next_busyHold;
  logic txNotEmpty;
  logic [ufs_pkg::FLAG_W-1:0] intStatus;
  logic [ufs_pkg::FLAG_W-1:0] next_intStatus;
  logic [ufs_pkg::FLAG_W-1:0] intMask;
  logic [ufs_pkg::FLAG_W-1:0] next_intMask;
  logic [ufs_pkg::FLAG_W-1:0] events;
  logic [ufs_pkg::FLAG_W-1:0] clearBits;
  logic [ufs_pkg::DAT_W-1:0] next_datOut;
  logic next_ack;
  logic next_irq;
  logic access;
  logic writeLow;

  ufs_flag_select u_select (
    .occ(occ),
    .fifoModeEnable(fifoModeEnable),
    .busyHold(busyHold),
    .flags(flags)
  );

  // busy keeper: once a character is queued, hold busy until the shift
  // engine reports the last stop bit gone; a fresh character re-arms it
  always_comb begin
    txNotEmpty = fifoModeEnable ? !occ.txFifoEmpty : occ.txHoldFull;
    next_busyHold = busyHold;
    if (txNotEmpty) begin
      next_busyHold = 1'b1;
    end else if (shiftDone) begin
      next_busyHold = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyHold <= 1'b0;
    end else begin
      busyHold <= next_busyHold;
    end
  end

  // events: a rising empty/full flag, or busy falling (transmit finished)
  always_comb begin
    next_prevFlags = flags;
    events = {flags.txEmpty & ~prevFlags.txEmpty,
              flags.rxFull & ~prevFlags.rxFull,
              flags.txFull & ~prevFlags.txFull,
              flags.rxEmpty & ~prevFlags.rxEmpty,
              prevFlags.busy & ~flags.busy};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevFlags <= ufs_pkg::FLAG_FIELD_RESET;
    end else begin
      prevFlags <= next_prevFlags;
    end
  end

  // bus slave: one wait state, ack for one cycle, then dropped
  always_comb begin
    access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    writeLow = access & wb_we_i & wb_sel_i[0];
    next_ack = access;
    clearBits = '0;
    next_intMask = intMask;
    if (writeLow && wb_adr_i == ufs_pkg::INT_STATUS_OFS) begin
      clearBits = wb_dat_i[ufs_pkg::FLAG_LSB +: ufs_pkg::FLAG_W];
    end
    if (writeLow && wb_adr_i == ufs_pkg::INT_MASK_OFS) begin
      next_intMask = wb_dat_i[ufs_pkg::FLAG_LSB +: ufs_pkg::FLAG_W];
    end
    // a new event in the clearing cycle survives the write of one
    next_intStatus = (intStatus & ~clearBits) | events;
    next_irq = |(next_intStatus & next_intMask);
    next_datOut = wb_dat_o;
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        ufs_pkg::FLAG_OFS: next_datOut = ufs_pkg::ufs_place_field(flags);
        ufs_pkg::INT_STATUS_OFS: next_datOut = ufs_pkg::ufs_place_field(intStatus);
        ufs_pkg::INT_MASK_OFS: next_datOut = ufs_pkg::ufs_place_field(intMask);
        default: next_datOut = '0;
      endcase
    end
  end

  // writes to the flag word are dropped: it has no storage to hit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      intStatus <= ufs_pkg::INT_STATUS_RESET;
      intMask <= ufs_pkg::INT_MASK_RESET;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datOut;
      intStatus <= next_intStatus;
      intMask <= next_intMask;
      irq <= next_irq;
    end
  end

endmodule // uart_flag_status_logic

`default_nettype wire

// ==== logic/ufs_flag_select.sv ====
// Purpose: picks holding-register or fifo occupancy as the source of each flag
// Assumes: occupancy inputs come from logic on the same clock
// Notes: purely combinational so a read sees the occupancy of this very cycle
`timescale 1ns/1ps
`default_nettype none

module ufs_flag_select (
  input wire ufs_pkg::ufs_occ_t occ,
  input wire logic fifoModeEnable,
  input wire logic busyHold,
  output ufs_pkg::ufs_flags_t flags
);

  logic txNotEmpty;

  always_comb begin
    txNotEmpty = fifoModeEnable ? !occ.txFifoEmpty : occ.txHoldFull;
    flags.txEmpty = !txNotEmpty;
    flags.rxFull = fifoModeEnable ? occ.rxFifoFull : occ.rxHoldFull;
    flags.txFull = fifoModeEnable ? occ.txFifoFull : occ.txHoldFull;
    flags.rxEmpty = fifoModeEnable ? occ.rxFifoEmpty : !occ.rxHoldFull;
    // busy rises with the first queued character, enabled port or not
    flags.busy = txNotEmpty | busyHold;
  end

endmodule // ufs_flag_select

`default_nettype wire
